// ---- edag_gate.sv ----
// edag_gate.sv: permission check for external debugger accesses to trace, perfmon and debug registers
// assumes one clock, synchronous warm reset, a same-clock debugger request port and a plain register port
`timescale 1ns/10ps
`default_nettype none
`include "edag_consts.svh"
module edag_gate (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  // feature straps
  input  wire logic                  i_realm_feature,
  input  wire logic                  i_trace_buffer_feature,
  input  wire logic                  i_perfmon_feature,
  input  wire logic                  i_debug_v84_feature,
  input  wire logic                  i_highest_exception_level,
  input  wire logic                  i_nonsecure_select,
  input  wire logic                  i_auth_override,
  // register port
  input  wire logic [3:0]            i_reg_addr,
  input  wire logic [31:0]           i_reg_wdata,
  input  wire logic                  i_reg_wr,
  input  wire logic                  i_reg_rd,
  output logic [31:0]                o_reg_rdata,
  // debugger request
  input  wire logic                  i_dbg_req,
  input  wire edag_pkg::edag_grp_type i_dbg_grp,
  input  wire edag_pkg::edag_sec_type i_dbg_sec,
  // answer to debugger
  output logic                       o_dbg_grant,
  output logic                       o_dbg_refuse
);
  import edag_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // straps are static but come from pins: two flip-flops each
  logic [6:0] strap_meta;
  logic [6:0] strap_sync;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      strap_meta <= 7'h00;
      strap_sync <= 7'h00;
    end else begin
      strap_meta <= {i_realm_feature, i_trace_buffer_feature, i_perfmon_feature, i_debug_v84_feature,
                     i_highest_exception_level, i_nonsecure_select, i_auth_override};
      strap_sync <= strap_meta;
    end
  end
  logic realm_ft;
  logic tbuf_ft;
  logic pmu_ft;
  logic v84_ft;
  logic top_el_ft;
  logic ns_sel;
  logic auth_ovr;
  assign {realm_ft, tbuf_ft, pmu_ft, v84_ft, top_el_ft, ns_sel, auth_ovr} = strap_sync;

  ////////////////////////////////////////////////////////////////////////////
  // group implemented: index 2 trace, 1 perfmon, 0 debug
  function automatic logic grp_present(input logic [1:0] idx, input logic trbe, input logic pmu);
    unique case (idx)
      2'h2:    grp_present = trbe;
      2'h1:    grp_present = pmu;
      default: grp_present = 1'b1;
    endcase
  endfunction

  // realm pairing of extension and disable, shared by all three groups
  function automatic logic realm_permit(input logic ext, input logic dis, input edag_sec_type sec);
    unique case ({ext, dis})
      2'b00: realm_permit = 1'b1;
      2'b01: realm_permit = (sec == EDAG_SEC_ROOT) || (sec == EDAG_SEC_SECURE);
      2'b10: realm_permit = (sec == EDAG_SEC_ROOT) || (sec == EDAG_SEC_REALM);
      2'b11: realm_permit = (sec == EDAG_SEC_ROOT);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  edag_state_type st;
  edag_state_type next_st;

  // effective disables: with no realm feature, no top level and non-secure select low they read as one
  logic [2:0] eff_dis;
  logic       force_dis;
  assign force_dis = !realm_ft && !top_el_ft && !ns_sel;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_eff
      assign eff_dis[g] = st.dis[g] || force_dis;
    end
  endgenerate

  logic permit;
  logic [1:0] gidx;
  always_comb begin
    gidx   = 2'h0;
    permit = 1'b0;
    unique case (i_dbg_grp)
      EDAG_GRP_TRACE: gidx = 2'h2;
      EDAG_GRP_PERF:  gidx = 2'h1;
      EDAG_GRP_DBG:   gidx = 2'h0;
      EDAG_GRP_NONE:  gidx = 2'h0;
    endcase
    if (i_dbg_grp == EDAG_GRP_NONE) begin
      permit = 1'b1;
    end else if (!grp_present(gidx, tbuf_ft, pmu_ft)) begin
      permit = 1'b1;
    end else if (realm_ft) begin
      permit = realm_permit(st.ext[gidx], st.dis[gidx], i_dbg_sec);
    end else if (gidx == 2'h1 && !v84_ft) begin
      permit = !eff_dis[gidx] || auth_ovr;
    end else begin
      permit = !(eff_dis[gidx] && i_dbg_sec == EDAG_SEC_NONSECURE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] cfg_view;
  logic [31:0] ext_view;
  always_comb begin
    next_st            = st;
    next_st.acc_grant  = 1'b0;
    next_st.acc_refuse = 1'b0;
    cfg_view = 32'h0000_0000;
    ext_view = 32'h0000_0000;
    cfg_view[`EDAG_BIT_TRACE_DIS] = st.dis[2] && tbuf_ft;
    cfg_view[`EDAG_BIT_PERF_DIS]  = st.dis[1] && pmu_ft;
    cfg_view[`EDAG_BIT_DBG_DIS]   = st.dis[0];
    ext_view[`EDAG_BIT_TRACE_EXT] = st.ext[2] && realm_ft && tbuf_ft;
    ext_view[`EDAG_BIT_PERF_EXT]  = st.ext[1] && realm_ft && pmu_ft;
    ext_view[`EDAG_BIT_DBG_EXT]   = st.ext[0] && realm_ft;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        `EDAG_ADDR_CONFIG: begin
          next_st.dis = {i_reg_wdata[`EDAG_BIT_TRACE_DIS] && tbuf_ft,
                         i_reg_wdata[`EDAG_BIT_PERF_DIS] && pmu_ft,
                         i_reg_wdata[`EDAG_BIT_DBG_DIS]};
        end
        `EDAG_ADDR_EXT: begin
          next_st.ext = {i_reg_wdata[`EDAG_BIT_TRACE_EXT], i_reg_wdata[`EDAG_BIT_PERF_EXT],
                         i_reg_wdata[`EDAG_BIT_DBG_EXT]} & {3{realm_ft}};
        end
        `EDAG_ADDR_STATUS: begin
          next_st.refuse_seen = st.refuse_seen & ~i_reg_wdata[2:0];
        end
        default: begin
        end
      endcase
    end
    if (i_dbg_req) begin
      next_st.acc_grant  = permit;
      next_st.acc_refuse = !permit;
      if (!permit && i_dbg_grp != EDAG_GRP_NONE) begin
        next_st.refuse_seen[gidx] = 1'b1;                                           // set wins over clear
      end
    end
    next_st.rdata = 32'h0000_0000;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        `EDAG_ADDR_CONFIG: next_st.rdata = cfg_view;
        `EDAG_ADDR_EXT:    next_st.rdata = ext_view;
        `EDAG_ADDR_STATUS: next_st.rdata = {29'h0000_0000, st.refuse_seen};
        default:           next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st.dis         <= {3{`EDAG_RST_DIS}};
      st.ext         <= {3{`EDAG_RST_EXT}};
      st.acc_grant   <= 1'b0;
      st.acc_refuse  <= 1'b0;
      st.rdata       <= 32'h0000_0000;
      st.refuse_seen <= 3'h0;
    end else begin
      st <= next_st;
    end
  end

  assign o_reg_rdata  = st.rdata;
  assign o_dbg_grant  = st.acc_grant;
  assign o_dbg_refuse = st.acc_refuse;
endmodule : edag_gate
`default_nettype wire

// ---- edag_consts.svh ----
// edag_consts.svh: offsets, field positions and reset values for the external debug access gate
// assumes inclusion by edag_pkg.sv and the gate module only
`ifndef EDAG_CONSTS_SVH
`define EDAG_CONSTS_SVH
`define EDAG_ADDR_CONFIG     4'h0
`define EDAG_ADDR_EXT        4'h1
`define EDAG_ADDR_STATUS     4'h2
`define EDAG_BIT_TRACE_DIS   22
`define EDAG_BIT_PERF_DIS    21
`define EDAG_BIT_DBG_DIS     20
`define EDAG_BIT_TRACE_EXT   2
`define EDAG_BIT_PERF_EXT    1
`define EDAG_BIT_DBG_EXT     0
`define EDAG_RST_DIS         1'h0
`define EDAG_RST_EXT         1'h0
`endif

// ---- edag_pkg.sv ----
// edag_pkg.sv: types for the external debug access gate
// assumes edag_consts.svh is on the include path
`include "edag_consts.svh"
package edag_pkg;
  typedef enum logic [1:0] {
    EDAG_SEC_ROOT      = 2'h0,
    EDAG_SEC_SECURE    = 2'h1,
    EDAG_SEC_REALM     = 2'h2,
    EDAG_SEC_NONSECURE = 2'h3
  } edag_sec_type;
  typedef enum logic [1:0] {
    EDAG_GRP_TRACE = 2'h0,
    EDAG_GRP_PERF  = 2'h1,
    EDAG_GRP_DBG   = 2'h2,
    EDAG_GRP_NONE  = 2'h3
  } edag_grp_type;
  typedef struct packed {
    logic [2:0]  dis;
    logic [2:0]  ext;
    logic        acc_grant;
    logic        acc_refuse;
    logic [31:0] rdata;
    logic [2:0]  refuse_seen;
  } edag_state_type;
endpackage : edag_pkg

// ---- edag_gate_assertions.sv ----
// edag_gate_assertions.sv: port-level checks on the access gate
// assumes a bind onto edag_gate, one clock, synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module edag_chk (
  // clock and reset
  input wire logic                   i_clk,
  input wire logic                   i_rst_n,
  // watched ports
  input wire logic                   i_realm_feature,
  input wire logic                   i_reg_rd,
  input wire logic [31:0]            o_reg_rdata,
  input wire logic                   i_dbg_req,
  input wire edag_pkg::edag_grp_type i_dbg_grp,
  input wire edag_pkg::edag_sec_type i_dbg_sec,
  input wire logic                   o_dbg_grant,
  input wire logic                   o_dbg_refuse
);
  import edag_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  a_answer_next: assert property (i_dbg_req |=> o_dbg_grant ^ o_dbg_refuse) else $error("no answer");
  a_no_stray: assert property (!$past(i_dbg_req) |-> !o_dbg_grant && !o_dbg_refuse) else $error("stray");
  a_not_both: assert property (!(o_dbg_grant && o_dbg_refuse)) else $error("both answers");
  a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0) else $error("stray rdata");
  a_reset_quiet: assert property ($rose(i_rst_n) |-> !o_dbg_grant && o_reg_rdata == 32'h0) else $error("reset");
  a_other_pass: assert property (i_dbg_req && i_dbg_grp == EDAG_GRP_NONE |=> o_dbg_grant) else $error("other");
  a_root_pass: assert property (i_dbg_req && i_dbg_sec == EDAG_SEC_ROOT && i_dbg_grp != EDAG_GRP_PERF
    |=> o_dbg_grant) else $error("root refused");
  // realm strap must have been low through the sync stages
  a_secure_pass: assert property (i_dbg_req && i_dbg_sec == EDAG_SEC_SECURE && i_dbg_grp != EDAG_GRP_PERF
    && !$past(i_realm_feature, 2) && !$past(i_realm_feature, 3) |=> o_dbg_grant) else $error("secure refused");
endmodule : edag_chk
////////////////////////////////////////////////////////////////////////////////
bind edag_gate edag_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_realm_feature(i_realm_feature),
  .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_dbg_req(i_dbg_req), .i_dbg_grp(i_dbg_grp),
  .i_dbg_sec(i_dbg_sec), .o_dbg_grant(o_dbg_grant), .o_dbg_refuse(o_dbg_refuse));
`default_nettype wire

// ---- edag_dbg_model.sv ----
// edag_dbg_model.sv: external debugger issuing single requests
// assumes the gate answers exactly one cycle after the request edge
`timescale 1ns/10ps
`default_nettype none
module edag_dbg_model (
  // clock and answer
  input  wire logic                  i_clk,
  input  wire logic                  i_grant,
  input  wire logic                  i_refuse,
  // request
  output logic                       o_req,
  output var edag_pkg::edag_grp_type o_grp,
  output var edag_pkg::edag_sec_type o_sec
);
  import edag_pkg::*;
  initial o_req = 1'h0;
  initial o_grp = EDAG_GRP_NONE;
  initial o_sec = EDAG_SEC_NONSECURE;
  task automatic access(input edag_grp_type g, input edag_sec_type s, output logic gr, output logic rf);
    @(posedge i_clk);
    o_req <= 1'h1;
    o_grp <= g;
    o_sec <= s;
    @(posedge i_clk);
    o_req <= 1'h0;
    // released lines flip so a stale value never looks valid
    o_grp <= edag_grp_type'(~g);
    o_sec <= edag_sec_type'(~s);
    @(posedge i_clk);
    gr = i_grant;
    rf = i_refuse;
  endtask : access
endmodule : edag_dbg_model
`default_nettype wire

// ---- tb_external_debug_access_gate.sv ----
// tb_external_debug_access_gate.sv: directed checks of the access gate
// assumes edag_pkg, edag_dbg_model and the bound checker are compiled first
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; $display("MISMATCH %0t bad value", $time); end end
module tb_external_debug_access_gate;
  import edag_pkg::*;
  logic         i_clk = 1'h0, i_rst_n = 1'h0, i_reg_wr = 1'h0, i_reg_rd = 1'h0, gr, rf, req, grant, refuse;
  logic [6:0]   st = 7'h7e;
  logic [3:0]   i_reg_addr = 4'h0;
  logic [31:0]  i_reg_wdata = 32'h0, o_reg_rdata;
  edag_grp_type grp;
  edag_sec_type sec;
  int           err_count = 0, check_count = 0;
  always #20 i_clk = ~i_clk;
  ////////////////////////////////////////////////////////////////////////////////
  edag_gate i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_realm_feature(st[6]), .i_trace_buffer_feature(st[5]),
    .i_perfmon_feature(st[4]), .i_debug_v84_feature(st[3]), .i_highest_exception_level(st[2]),
    .i_nonsecure_select(st[1]), .i_auth_override(st[0]), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_dbg_req(req), .i_dbg_grp(grp),
    .i_dbg_sec(sec), .o_dbg_grant(grant), .o_dbg_refuse(refuse));
  edag_dbg_model i_mdl (.i_clk(i_clk), .i_grant(grant), .i_refuse(refuse), .o_req(req), .o_grp(grp),
    .o_sec(sec));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_reg_wr <= 1'h1;
    i_reg_addr <= a;
    i_reg_wdata <= v;
    @(posedge i_clk);
    i_reg_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_reg_rd <= 1'h1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'h0;
    @(posedge i_clk);
    `CHK(o_reg_rdata, e)
  endtask : rd
  task automatic ac(input int g, input int s, input logic e);
    i_mdl.access(edag_grp_type'(g), edag_sec_type'(s), gr, rf);
    `CHK(gr, e)
    `CHK(rf, !e)
  endtask : ac
  task automatic strap(input logic [6:0] v);
    st <= v;
    repeat (3) @(posedge i_clk);
  endtask : strap
  task automatic rst();
    i_rst_n <= 1'h0;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'h1;
    repeat (3) @(posedge i_clk);
  endtask : rst
  function automatic logic ok(input int c, input int s);
    return c == 0 || s == 0 || (c == 1 && s == 1) || (c == 2 && s == 2);
  endfunction : ok
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////////
  // hang guard: a stuck run is scored as a failure
  initial begin
    #2000000;
    err_count++;
    give_verdict();
  end
  initial begin
    rst();
    rd(4'h0, 32'h0);
    rd(4'hf, 32'h0);
    for (int g = 0; g < 3; g++)
      for (int c = 0; c < 4; c++) begin
        wr(4'h0, 32'(c[0]) << (22 - g));
        wr(4'h1, 32'(c[1]) << (2 - g));
        for (int s = 0; s < 4; s++)
          ac(g, s, ok(c, s));
      end
    st <= 7'h3e;
    rst();
    rd(4'h0, 32'h0);
    for (int g = 0; g < 3; g++) begin
      wr(4'h0, 32'h400000 >> g);
      for (int s = 0; s < 4; s++)
        ac(g, s, s != 3);
    end
    rd(4'h2, 32'h7);
    wr(4'h2, 32'h7);
    rd(4'h2, 32'h0);
    wr(4'h0, 32'h0);
    ac(0, 3, 1'h1);
    wr(4'h0, 32'h200000);
    strap(7'h36);
    ac(1, 0, 1'h0);
    strap(7'h37);
    ac(1, 0, 1'h1);
    strap(7'h38);
    wr(4'h0, 32'h0);
    for (int g = 0; g < 3; g++) begin
      ac(g, 3, 1'h0);
      ac(g, 1, 1'h1);
    end
    rd(4'h0, 32'h0);
    // trace and perfmon absent: their bits stay zero and accesses pass
    strap(7'h08);
    wr(4'h0, 32'h700000);
    rd(4'h0, 32'h100000);
    wr(4'h1, 32'h7);
    rd(4'h1, 32'h0);
    ac(0, 3, 1'h1);
    ac(1, 3, 1'h1);
    ac(2, 3, 1'h0);
    ac(3, 3, 1'h1);
    give_verdict();
  end
endmodule : tb_external_debug_access_gate
`default_nettype wire
